/* File: rtl/abfp_pkg.sv */
package abfp_pkg;

  // ----------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;
  localparam int unsigned SYNC_STAGES = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        FLAG_IDLE   = 1'h1;
  localparam logic [7:0]  DATA_RESET  = 8'h00;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic       valid;
  } abfp_byte_t;

  // pin group seen from the external controller
  typedef struct packed {
    logic       rd_n;
    logic       wr_n;
    logic       send_now_wake_n;
    logic [7:0] data;
  } abfp_pins_in_t;

  typedef struct packed {
    logic       rx_avail_n;
    logic       rx_avail_oe;
    logic       tx_space_n;
    logic       tx_space_oe;
    logic [7:0] data;
    logic       data_oe;
  } abfp_pins_out_t;

  typedef enum logic [1:0] {
    ABFP_RD_IDLE  = 2'b00,
    ABFP_RD_LOW   = 2'b01,
    ABFP_RD_GAP   = 2'b10
  } abfp_rd_state_t;

endpackage : abfp_pkg

/* File: rtl/abfp_port.sv */
// Overview of operation
// (RULE1) channel active only when configuration selects mode
// (RULE2) transfers timed by strobe falling edges
// (RULE3) data lines driven only while read low
// (RULE4) receive flag low when byte waiting
// (RULE5) receive flag high after each read
// (RULE6) both flags undriven during reset
// (RULE7) transmit flag low while space exists
// (RULE8) falling read presents head byte
// (RULE9) rising read advances receive buffer
// (RULE10) falling write captures data byte
// (RULE11) wake pulse in suspend requests resume
// (RULE12) wake pulse in normal flushes transmit
// (RULE13) controller holds wake high before pulsing
// (RULE14) controller keeps write data stable
`timescale 1ns/1ps
`default_nettype none
module abfp_port #(
  parameter int unsigned DEPTH = abfp_pkg::FIFO_DEPTH
) (
  input  wire logic                  REF_CLK_I,
  input  wire logic                  RESET_I,
  input  wire logic                  MODE_EN_I,
  input  wire logic                  REMOTE_WAKE_EN_I,
  input  wire logic                  SUSPENDED_I,
  input  wire abfp_pkg::abfp_pins_in_t PINS_I,
  output var  abfp_pkg::abfp_pins_out_t PINS_O,
  output var  logic                  POWER_ENABLE_N_O,
  input  wire abfp_pkg::abfp_byte_t  RX_IN_I,
  output var  logic                  RX_READY_O,
  output var  abfp_pkg::abfp_byte_t  TX_OUT_O,
  input  wire logic                  TX_READY_I,
  output var  logic                  RESUME_REQ_O,
  output var  logic                  FLUSH_REQ_O
);
  import abfp_pkg::*;

  localparam int unsigned AW = $clog2(DEPTH);

  // wrap-bit pointers only serve power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
    $error("DEPTH must be a power of two, at least 2");
  end

  function automatic logic [AW:0] inc_ptr(input logic [AW:0] p);
    inc_ptr = p + {{AW{1'b0}}, 1'b1};
  endfunction : inc_ptr

  function automatic logic is_full(input logic [AW:0] wp,
                                   input logic [AW:0] rp);
    is_full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  endfunction : is_full

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic rd_lvl;
  logic rd_fall;
  logic rd_rise;
  logic wr_fall;
  logic wk_fall;

  abfp_sync #(.INIT(1'b1)) u_rd (
    .REF_CLK_I (REF_CLK_I),
    .RESET_I   (RESET_I),
    .async_i   (PINS_I.rd_n),
    .level_o   (rd_lvl),
    .fall_o    (rd_fall),
    .rise_o    (rd_rise)
  );

  abfp_sync #(.INIT(1'b1)) u_wr (
    .REF_CLK_I (REF_CLK_I),
    .RESET_I   (RESET_I),
    .async_i   (PINS_I.wr_n),
    .level_o   (),
    .fall_o    (wr_fall),
    .rise_o    ()
  );

  abfp_sync #(.INIT(1'b1)) u_wk (
    .REF_CLK_I (REF_CLK_I),
    .RESET_I   (RESET_I),
    .async_i   (PINS_I.send_now_wake_n),
    .level_o   (),
    .fall_o    (wk_fall),
    .rise_o    ()
  );

  // write data sampled through the same three-stage delay as strobe
  logic [7:0] wd_s1_reg;
  logic [7:0] wd_s2_reg;
  logic [7:0] wd_s3_reg;

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      wd_s1_reg <= DATA_RESET;
      wd_s2_reg <= DATA_RESET;
      wd_s3_reg <= DATA_RESET;
    end else begin
      wd_s1_reg <= PINS_I.data;
      wd_s2_reg <= wd_s1_reg;
      wd_s3_reg <= wd_s2_reg;
    end
  end

  // ----------------------------------------------------------------
  // receive buffer and read sequence
  // ----------------------------------------------------------------
  logic [7:0]     rx_mem_reg  [DEPTH];
  logic [AW:0]    rx_wp_reg;
  logic [AW:0]    rx_wp_next;
  logic [AW:0]    rx_rp_reg;
  logic [AW:0]    rx_rp_next;
  abfp_rd_state_t rd_st_reg;
  abfp_rd_state_t rd_st_next;
  logic           rx_push;
  logic           rx_empty;
  logic           rx_full;
  logic           rx_rdy_reg;
  logic           rx_rdy_next;

  assign rx_empty = (rx_wp_reg == rx_rp_reg);
  assign rx_full  = is_full(rx_wp_reg, rx_rp_reg);
  // ready is registered: a push follows exactly what the source saw
  assign rx_push  = RX_IN_I.valid && rx_rdy_reg && !rx_full;

  always_comb begin
    rx_wp_next = rx_wp_reg;
    rx_rp_next = rx_rp_reg;
    rd_st_next = rd_st_reg;
    if (rx_push) begin
      rx_wp_next = inc_ptr(rx_wp_reg);
    end
    case (rd_st_reg)
      ABFP_RD_IDLE: begin
        if (rd_fall && MODE_EN_I) begin // (RULE2)
          rd_st_next = ABFP_RD_LOW;
        end
      end
      ABFP_RD_LOW: begin
        if (rd_rise) begin
          if (!rx_empty) begin
            rx_rp_next = inc_ptr(rx_rp_reg); // (RULE9)
          end
          rd_st_next = ABFP_RD_GAP;
        end
      end
      ABFP_RD_GAP: begin
        rd_st_next = ABFP_RD_IDLE; // (RULE5)
      end
      default: begin
        rd_st_next = ABFP_RD_IDLE;
      end
    endcase
    rx_rdy_next = MODE_EN_I && !is_full(rx_wp_next, rx_rp_next);
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      rx_wp_reg  <= '0;
      rx_rp_reg  <= '0;
      rd_st_reg  <= ABFP_RD_IDLE;
      rx_rdy_reg <= 1'b0;
    end else begin
      rx_wp_reg  <= rx_wp_next;
      rx_rp_reg  <= rx_rp_next;
      rd_st_reg  <= rd_st_next;
      rx_rdy_reg <= rx_rdy_next;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (rx_push) begin
      rx_mem_reg[rx_wp_reg[AW-1:0]] <= RX_IN_I.data;
    end
  end

  // ----------------------------------------------------------------
  // transmit capture and flush/resume
  // ----------------------------------------------------------------
  abfp_byte_t tx_reg;
  abfp_byte_t tx_next;
  logic       flush_reg;
  logic       flush_next;
  logic       resume_reg;
  logic       resume_next;

  always_comb begin
    tx_next     = tx_reg;
    flush_next  = 1'b0;
    resume_next = 1'b0;
    if (tx_reg.valid && TX_READY_I) begin
      tx_next.valid = 1'b0;
    end
    if (wr_fall && MODE_EN_I && !tx_reg.valid) begin
      tx_next.data  = wd_s3_reg; // (RULE10)
      tx_next.valid = 1'b1;
    end
    if (wk_fall && MODE_EN_I) begin
      if (SUSPENDED_I) begin
        resume_next = REMOTE_WAKE_EN_I; // (RULE11)
      end else begin
        flush_next = 1'b1; // (RULE12)
      end
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      tx_reg     <= '{data: DATA_RESET, valid: 1'b0};
      flush_reg  <= 1'b0;
      resume_reg <= 1'b0;
    end else begin
      tx_reg     <= tx_next;
      flush_reg  <= flush_next;
      resume_reg <= resume_next;
    end
  end

  // ----------------------------------------------------------------
  // pin drivers, all registered
  // ----------------------------------------------------------------
  abfp_pins_out_t po_reg;
  abfp_pins_out_t po_next;
  logic           pwr_reg;

  always_comb begin
    po_next             = po_reg;
    po_next.rx_avail_oe = MODE_EN_I; // (RULE1)
    po_next.tx_space_oe = MODE_EN_I;
    // flag high after read until next idle check
    po_next.rx_avail_n  = (rd_st_next == ABFP_RD_IDLE) ?
                          rx_empty : po_reg.rx_avail_n; // (RULE4)
    if (rd_st_reg == ABFP_RD_LOW && rd_rise) begin
      po_next.rx_avail_n = FLAG_IDLE; // (RULE5)
    end
    po_next.tx_space_n  = tx_next.valid; // (RULE7)
    po_next.data_oe     = MODE_EN_I && !rd_lvl; // (RULE3)
    if (rd_fall) begin
      po_next.data = rx_mem_reg[rx_rp_reg[AW-1:0]]; // (RULE8)
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      // flags released; pull-up shows them high (RULE6)
      po_reg  <= '{rx_avail_n: FLAG_IDLE, rx_avail_oe: 1'b0,
                   tx_space_n: FLAG_IDLE, tx_space_oe: 1'b0,
                   data: DATA_RESET, data_oe: 1'b0};
      pwr_reg <= FLAG_IDLE;
    end else begin
      po_reg  <= po_next;
      pwr_reg <= SUSPENDED_I;
    end
  end

  assign PINS_O           = po_reg;
  assign POWER_ENABLE_N_O = pwr_reg;
  assign RX_READY_O       = rx_rdy_reg;
  assign TX_OUT_O         = tx_reg;
  assign RESUME_REQ_O     = resume_reg;
  assign FLUSH_REQ_O      = flush_reg;

endmodule : abfp_port
`default_nettype wire

/* File: rtl/abfp_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module abfp_sync #(
  parameter logic INIT = 1'b1
) (
  input  wire logic REF_CLK_I,
  input  wire logic RESET_I,
  input  wire logic async_i,
  output var  logic level_o,
  output var  logic fall_o,
  output var  logic rise_o
);
  import abfp_pkg::*;

  // ----------------------------------------------------------------
  // three stages, change accepted when stages two and three agree
  // ----------------------------------------------------------------
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;

  always_comb begin
    sh_next  = {sh_reg[1:0], async_i};
    lvl_next = lvl_reg;
    if (sh_reg[2] == sh_reg[1]) begin
      lvl_next = sh_reg[2];
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (RESET_I) begin
      sh_reg  <= {3{INIT}};
      lvl_reg <= INIT;
    end else begin
      sh_reg  <= sh_next;
      lvl_reg <= lvl_next;
    end
  end

  assign level_o = lvl_reg;
  assign fall_o  = lvl_reg & ~lvl_next;
  assign rise_o  = ~lvl_reg & lvl_next;

endmodule : abfp_sync
`default_nettype wire

/* File: tb/abfp_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
module abfp_ctrl_model (
  input  wire abfp_pkg::abfp_pins_out_t pins_i,
  input  wire logic                     clk_i,
  input  wire logic [7:0]               bus_i,
  output var  abfp_pkg::abfp_pins_in_t  pins_o
);
  import abfp_pkg::*;
  // strobes idle high, released data shows inverse of last value,
  // released flags read high through the pull-up
  initial pins_o = 11'h700;
  task automatic rd(input int slow, output logic [7:0] b);
    for (int i = 0; i < 300 && !(pins_i.rx_avail_oe === 1'h1 &&
         pins_i.rx_avail_n === 1'h0); i++)
      @(posedge clk_i);
    @(posedge clk_i);
    #2 pins_o.rd_n = 1'h0;
    repeat (7 + slow) @(posedge clk_i);
    b = bus_i;
    #2 pins_o.rd_n = 1'h1;
    repeat (8) @(posedge clk_i);
  endtask : rd
  task automatic wr(input int slow, input logic [7:0] b);
    for (int i = 0; i < 300 && !(pins_i.tx_space_oe === 1'h1 &&
         pins_i.tx_space_n === 1'h0); i++)
      @(posedge clk_i);
    #2 pins_o.data = b;
    @(posedge clk_i);
    #2 pins_o.wr_n = 1'h0;
    repeat (7 + slow) @(posedge clk_i);
    #2 pins_o.wr_n = 1'h1;
    pins_o.data = ~b;
    repeat (8) @(posedge clk_i);
  endtask : wr
  task automatic wake();
    @(posedge clk_i);
    #2 pins_o.send_now_wake_n = 1'h0;
    repeat (6) @(posedge clk_i);
    #2 pins_o.send_now_wake_n = 1'h1;
    repeat (8) @(posedge clk_i);
  endtask : wake
endmodule : abfp_ctrl_model
`default_nettype wire

/* File: tb/abfp_port_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module abfp_port_checker (
  input wire logic                     REF_CLK_I,
  input wire logic                     RESET_I,
  input wire logic                     MODE_EN_I,
  input wire logic                     REMOTE_WAKE_EN_I,
  input wire logic                     SUSPENDED_I,
  input wire abfp_pkg::abfp_pins_in_t  PINS_I,
  input wire abfp_pkg::abfp_pins_out_t PINS_O,
  input wire logic                     POWER_ENABLE_N_O,
  input wire logic                     RESUME_REQ_O,
  input wire logic                     FLUSH_REQ_O
);
  import abfp_pkg::*;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence rd_fall; MODE_EN_I && $fell(PINS_I.rd_n); endsequence
  sequence rd_rise; MODE_EN_I && $rose(PINS_I.rd_n); endsequence
  sequence wk_fall; MODE_EN_I && $fell(PINS_I.send_now_wake_n); endsequence
  chk_reset_quiet: assert property (disable iff (1'h0) RESET_I |=>
    !PINS_O.rx_avail_oe && !PINS_O.tx_space_oe) else $error("flag driven");
  chk_rd_drive: assert property (rd_fall |-> ##[2:6] PINS_O.data_oe)
    else $error("data not driven on read");
  chk_rd_release: assert property (rd_rise |-> ##[2:6] !PINS_O.data_oe)
    else $error("data held after read");
  chk_rx_flag_up: assert property (rd_rise |-> ##[2:6] PINS_O.rx_avail_n)
    else $error("receive flag not raised");
  chk_wake_resume: assert property (wk_fall ##0
    (SUSPENDED_I && REMOTE_WAKE_EN_I) |-> ##[2:6] RESUME_REQ_O)
    else $error("resume missing");
  chk_wake_flush: assert property (wk_fall ##0 !SUSPENDED_I
    |-> ##[2:6] FLUSH_REQ_O) else $error("flush missing");
  chk_flush_awake: assert property (FLUSH_REQ_O |-> !POWER_ENABLE_N_O)
    else $error("flush while suspended");
  chk_resume_asleep: assert property (RESUME_REQ_O |->
    POWER_ENABLE_N_O && REMOTE_WAKE_EN_I) else $error("stray resume");
  chk_mode_off: assert property (!MODE_EN_I |=>
    !(PINS_O.rx_avail_oe || PINS_O.tx_space_oe || PINS_O.data_oe))
    else $error("pins driven with mode off");
endmodule : abfp_port_checker
bind abfp_port abfp_port_checker u_chk (.REF_CLK_I, .RESET_I, .MODE_EN_I,
  .REMOTE_WAKE_EN_I, .SUSPENDED_I, .PINS_I, .PINS_O, .POWER_ENABLE_N_O,
  .RESUME_REQ_O, .FLUSH_REQ_O);
`default_nettype wire

/* File: tb/async_byte_fifo_port_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module async_byte_fifo_port_bench;
  import abfp_pkg::*;
  `define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
    $display("Error %s exp %h got %h", n, e, a); end end
  logic ref_clk = 0, rst = 1, mode = 1, wk_en = 1, susp = 0, tx_rdy = 0;
  logic rx_rdy, pwr_n, resume, flush;
  logic [7:0] bus, b, e, sent[$], txq[$];
  abfp_byte_t rx_in = '0, tx_out;
  abfp_pins_in_t pins_in, ctrl;
  abfp_pins_out_t pins_out;
  int n_fail = 0, n_checks = 0, n_flush = 0, n_res = 0;
  assign bus = pins_out.data_oe ? pins_out.data : ctrl.data;
  assign pins_in = {ctrl.rd_n, ctrl.wr_n, ctrl.send_now_wake_n, bus};
  always #12.5 ref_clk = ~ref_clk;
  abfp_port #(.DEPTH(FIFO_DEPTH)) u_abfp_port (.REF_CLK_I(ref_clk),
    .RESET_I(rst), .MODE_EN_I(mode), .REMOTE_WAKE_EN_I(wk_en),
    .SUSPENDED_I(susp), .PINS_I(pins_in), .PINS_O(pins_out),
    .POWER_ENABLE_N_O(pwr_n), .RX_IN_I(rx_in), .RX_READY_O(rx_rdy),
    .TX_OUT_O(tx_out), .TX_READY_I(tx_rdy), .RESUME_REQ_O(resume),
    .FLUSH_REQ_O(flush));
  abfp_ctrl_model u_abfp_ctrl_model (.pins_i(pins_out), .clk_i(ref_clk),
    .bus_i(bus), .pins_o(ctrl));
  always @(posedge ref_clk) begin
    if (tx_out.valid === 1'h1 && tx_rdy) txq.push_back(tx_out.data);
    n_flush += (flush === 1'h1);
    n_res += (resume === 1'h1);
    tx_rdy <= #2 1'($urandom);
  end
  function automatic logic [7:0] pick(input int i);
    if (i == 0) return 8'h00;
    if (i == 1) return 8'hFF;
    return 8'($urandom);
  endfunction : pick
  task automatic final_report;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  initial begin
    #200000 n_fail++;
    final_report;
  end
  initial begin
    void'($urandom(38));
    repeat (3) @(posedge ref_clk);
    #2 `CHK("rx_oe", 1'h0, pins_out.rx_avail_oe)
    `CHK("tx_oe", 1'h0, pins_out.tx_space_oe)
    rst = 0;
    repeat (6) @(posedge ref_clk);
    `CHK("tx_space", 1'h0, pins_out.tx_space_n)
    $display("end reset");
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      b = pick(i);
      sent.push_back(b);
      rx_in <= #2 '{b, 1'h1};
      @(posedge ref_clk);
    end
    rx_in <= #2 '0;
    #3 `CHK("rx_full", 1'h0, rx_rdy)
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      u_abfp_ctrl_model.rd($urandom_range(3, 0), b);
      e = sent.pop_front();
      `CHK("rd_data", e, b)
    end
    `CHK("rx_empty", 1'h1, pins_out.rx_avail_n)
    $display("end receive");
    for (int i = 0; i < 12; i++) begin
      b = pick(i);
      sent.push_back(b);
      u_abfp_ctrl_model.wr($urandom_range(3, 0), b);
    end
    repeat (40) @(posedge ref_clk);
    `CHK("tx_count", sent.size(), txq.size())
    while (sent.size() > 0 && txq.size() > 0) begin
      e = sent.pop_front();
      b = txq.pop_front();
      `CHK("tx_data", e, b)
    end
    $display("end transmit");
    u_abfp_ctrl_model.wake();
    #2 susp = 1;
    u_abfp_ctrl_model.wake();
    #2 wk_en = 0;
    u_abfp_ctrl_model.wake();
    `CHK("flush", 1, n_flush)
    `CHK("resume", 1, n_res)
    $display("end wake");
    #2 mode = 0;
    repeat (3) @(posedge ref_clk);
    #1 `CHK("mode_off", 1'h0, pins_out.tx_space_oe)
    $display("end mode");
    final_report;
  end
endmodule : async_byte_fifo_port_bench
`default_nettype wire
